// ===== ends_model.sv
/*
  Far-side model: upstream sample source and downstream encoder.
  Assumes the bench names the next sample and the encoder stall modes.
*/
module ends_model
  import lin_clamp_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic signed [12:0] next_sample,
  input  wire logic               hold_off,
  input  wire logic               jitter_en,
  output logic signed      [12:0] sample_in,
  output logic                    out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 53543;
  initial begin
    sample_in = 13'sh0000;
    out_ready = 1'b1;
  end
  // source holds its sample as a level; encoder may stall at random
  always @(posedge core_clk) begin
    #1;
    sample_in = next_sample;
    out_ready = !hold_off && (!jitter_en || ($random(seed) % 2 != 0));
  end
endmodule

// ===== lin_clamp_pkg.sv
/*
  Constants, register map and carrier types of the table, trim and clamp path.
  Assumes a single 10 MHz core clock and configuration written by a local port.
*/
package lin_clamp_pkg;

  // register map (word addresses on the configuration port)
  localparam logic [4:0]  ADDR_LIMITS   = 5'h08;
  localparam logic [4:0]  ADDR_TABLE0   = 5'h0a;
  localparam logic [4:0]  ADDR_TAIL     = 5'h12;
  localparam logic [4:0]  ADDR_POST     = 5'h13;
  localparam int          TABLE_REGS    = 9;
  localparam int          NUM_POINTS    = 17;

  // field positions
  localparam int          FIELD_HI_LSB  = 12;
  localparam int          ENABLE_BIT    = 12;
  localparam int          BIN_BIT       = 13;
  localparam int          OUT_INV_BIT   = 14;
  localparam int          IN_INV_BIT    = 15;
  localparam logic [23:0] TAIL_MASK     = 24'h00ffff;

  // values after reset
  localparam logic [23:0] LIMITS_RST    = 24'h000fff;
  localparam logic [23:0] TABLE_RST     = 24'h000000;
  localparam logic [23:0] POST_RST      = 24'h000000;

  // sample timing
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          SAMPLE_HZ     = 16_000;
  localparam int          TICK_CYCLES   = CLK_HZ / SAMPLE_HZ;
  localparam logic [9:0]  TICK_LAST     = 10'(TICK_CYCLES - 1);

  // table levels and limits
  localparam logic signed [13:0] Y_FIRST    = -14'sd2048;
  localparam logic signed [13:0] Y_LAST     = 14'sd2048;
  localparam logic signed [13:0] BIN_BELOW  = -14'sd3072;
  localparam logic signed [23:0] EXTRAP_MIN = -24'sd2304;
  localparam logic signed [23:0] EXTRAP_MAX = 24'sd2304;
  localparam int                 Y_STEP_SH  = 8;
  localparam logic [4:0]         CNT_ABOVE  = 5'd17;
  localparam logic [4:0]         SEG_LAST   = 5'd15;

  // post-table trim and conversion
  localparam logic signed [13:0] GAIN_ONE   = 14'sd2048;
  localparam int                 GAIN_SH    = 11;
  localparam logic signed [27:0] POST_MIN   = -28'sd2048;
  localparam logic signed [27:0] POST_MAX   = 28'sd2047;
  localparam logic [11:0]        UNSIGN_OFS = 12'h800;

  // divider
  localparam int          DIV_BITS      = 21;
  localparam logic [4:0]  DIV_LAST      = 5'(DIV_BITS - 1);

  // output buffer
  localparam int          SAMPLE_W      = 12;
  localparam int          FIFO_DEPTH    = 4;

  typedef struct packed {
    logic        en;
    logic [4:0]  addr;
    logic [23:0] data;
  } cfg_write_t;

  typedef enum logic [1:0] {st_idle, st_div, st_post} path_state_t;

endpackage

// ===== lin_trim_clamp.sv
/*
  Table lookup (interpolating or binning), post-table gain and offset,
  signed to unsigned conversion and clamp, one result per 16 kHz tick.
  Assumes synchronous inputs, a compensated sample held by the upstream
  stage and an encoder that drains the output FIFO.
*/
module lin_trim_clamp
  import lin_clamp_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  input  wire logic signed [12:0]  sample_in,
  input  wire cfg_write_t          cfg_wr,
  input  wire logic        [4:0]   cfg_rd_addr,
  output logic             [23:0]  cfg_rd_data,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output logic             [11:0]  out_data
);

  // configuration registers
  logic [23:0] limits_reg, limits_next;
  logic [23:0] post_reg,   post_next;
  logic [23:0] table_reg [TABLE_REGS];
  logic [23:0] table_next [TABLE_REGS];
  logic [23:0] rd_data_reg, rd_data_next;

  always_comb begin
    limits_next  = limits_reg;
    post_next    = post_reg;
    table_next   = table_reg;
    rd_data_next = 24'h000000;
    if (cfg_wr.en) begin
      if (cfg_wr.addr == ADDR_LIMITS) begin
        limits_next = cfg_wr.data;
      end
      if (cfg_wr.addr == ADDR_POST) begin
        post_next = cfg_wr.data;
      end
      for (int k = 0; k < TABLE_REGS; k++) begin
        if (cfg_wr.addr == ADDR_TABLE0 + 5'(k)) begin
          table_next[k] = (k == TABLE_REGS - 1) ? (cfg_wr.data & TAIL_MASK) : cfg_wr.data;
        end
      end
    end
    if (cfg_rd_addr == ADDR_LIMITS) begin
      rd_data_next = limits_reg;
    end
    if (cfg_rd_addr == ADDR_POST) begin
      rd_data_next = post_reg;
    end
    for (int k = 0; k < TABLE_REGS; k++) begin
      if (cfg_rd_addr == ADDR_TABLE0 + 5'(k)) begin
        rd_data_next = table_reg[k];
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      limits_reg  <= LIMITS_RST;
      post_reg    <= POST_RST;
      rd_data_reg <= 24'h000000;
      for (int k = 0; k < TABLE_REGS; k++) begin
        table_reg[k] <= TABLE_RST;
      end
    end else if (clk_en) begin
      limits_reg  <= limits_next;
      post_reg    <= post_next;
      rd_data_reg <= rd_data_next;
      table_reg   <= table_next;
    end
  end

  assign cfg_rd_data = rd_data_reg;

  // control fields
  logic        tbl_en;
  logic        bin_en;
  logic        out_inv;
  logic        in_inv;
  logic [11:0] clamp_hi;
  logic [11:0] clamp_lo;

  assign tbl_en   = table_reg[TABLE_REGS-1][ENABLE_BIT];
  assign bin_en   = table_reg[TABLE_REGS-1][BIN_BIT];
  assign out_inv  = table_reg[TABLE_REGS-1][OUT_INV_BIT];
  assign in_inv   = table_reg[TABLE_REGS-1][IN_INV_BIT];
  assign clamp_hi = limits_reg[11:0];
  assign clamp_lo = limits_reg[FIELD_HI_LSB +: 12];

  // thresholds and comparators
  logic signed [12:0]    x_eff;
  logic signed [11:0]    thr [NUM_POINTS];
  logic [NUM_POINTS-1:0] ge;

  always_comb begin
    x_eff = sample_in;
    if (in_inv) begin
      x_eff = (sample_in == -13'sd4096) ? 13'sd4095 : -sample_in;
    end
  end

  for (genvar i = 0; i < NUM_POINTS; i++) begin : g_point
    assign thr[i] = table_reg[i/2][(i%2)*FIELD_HI_LSB +: 12];
    assign ge[i]  = (x_eff >= 13'(thr[i]));
  end

  // sample tick
  logic [9:0] tick_cnt_reg, tick_cnt_next;
  logic       tick;

  assign tick = (tick_cnt_reg == TICK_LAST);

  always_comb begin
    tick_cnt_next = tick ? 10'h000 : tick_cnt_reg + 10'h001;
  end

  // datapath state
  path_state_t        state_reg, state_next;
  logic signed [13:0] y3_reg, y3_next;
  logic signed [13:0] ybase_reg, ybase_next;
  logic [20:0]        quo_reg, quo_next;
  logic [13:0]        rem_reg, rem_next;
  logic [12:0]        den_reg, den_next;
  logic [4:0]         div_cnt_reg, div_cnt_next;
  logic               neg_reg, neg_next;
  logic               extrap_reg, extrap_next;
  logic [11:0]        word_reg, word_next;
  logic               pending_reg, pending_next;
  logic               fifo_ready;

  logic [4:0]         cnt;
  logic [4:0]         seg;
  logic signed [13:0] diff;
  logic [13:0]        diff_mag;
  logic signed [12:0] den_s;
  logic [13:0]        rem_sh;
  logic [20:0]        q_val;
  logic signed [23:0] y_sum;
  logic signed [13:0] y3_o;
  logic signed [13:0] factor;
  logic signed [27:0] prod;
  logic signed [27:0] post_val;
  logic [11:0]        y5;

  always_comb begin
    state_next   = state_reg;
    y3_next      = y3_reg;
    ybase_next   = ybase_reg;
    quo_next     = quo_reg;
    rem_next     = rem_reg;
    den_next     = den_reg;
    div_cnt_next = div_cnt_reg;
    neg_next     = neg_reg;
    extrap_next  = extrap_reg;
    word_next    = word_reg;
    pending_next = pending_reg && !fifo_ready;
    cnt          = 5'd0;
    for (int i = 0; i < NUM_POINTS; i++) begin
      cnt = cnt + 5'(ge[i]);
    end
    seg      = (cnt == 5'd0) ? 5'd0 : ((cnt == CNT_ABOVE) ? SEG_LAST : cnt - 5'd1);
    diff     = 14'(x_eff) - 14'(thr[seg]);
    diff_mag = diff[13] ? 14'(-diff) : 14'(diff);
    den_s    = 13'(thr[seg + 5'd1]) - 13'(thr[seg]);
    rem_sh   = {rem_reg[12:0], quo_reg[20]};
    q_val    = 21'h000000;
    y_sum    = 24'sd0;
    y3_o     = (tbl_en && out_inv) ? -y3_reg : y3_reg;
    factor   = GAIN_ONE + 14'(signed'(post_reg[11:0]));
    prod     = 28'(y3_o) * 28'(factor);
    post_val = (prod >>> GAIN_SH) + 28'(signed'(post_reg[FIELD_HI_LSB +: 12]));
    y5       = 12'h000;
    case (state_reg)
      st_idle: begin
        if (tick && !pending_reg) begin
          if (!tbl_en) begin
            y3_next    = 14'(sample_in);
            state_next = st_post;
          end else if (bin_en) begin
            if (cnt == 5'd0) begin
              y3_next = BIN_BELOW;
            end else begin
              y3_next = Y_FIRST + 14'({cnt - 5'd1, 8'h00});
            end
            state_next = st_post;
          end else begin
            ybase_next   = Y_FIRST + 14'({seg, 8'h00});
            neg_next     = diff[13];
            extrap_next  = (cnt == 5'd0) || (cnt == CNT_ABOVE);
            quo_next     = {diff_mag[12:0], 8'h00};
            rem_next     = 14'h0000;
            den_next     = den_s;
            div_cnt_next = 5'd0;
            state_next   = st_div;
          end
        end
      end
      st_div: begin
        if (rem_sh >= {1'b0, den_reg}) begin
          rem_next = rem_sh - {1'b0, den_reg};
          quo_next = {quo_reg[19:0], 1'b1};
        end else begin
          rem_next = rem_sh;
          quo_next = {quo_reg[19:0], 1'b0};
        end
        div_cnt_next = div_cnt_reg + 5'd1;
        if (div_cnt_reg == DIV_LAST) begin
          q_val = (den_reg == 13'h0000) ? 21'h000000 : quo_next;
          y_sum = neg_reg ? 24'(ybase_reg) - 24'(q_val) : 24'(ybase_reg) + 24'(q_val);
          if (y_sum < EXTRAP_MIN) begin
            y3_next = 14'(EXTRAP_MIN);
          end else if (y_sum > EXTRAP_MAX) begin
            y3_next = 14'(EXTRAP_MAX);
          end else begin
            y3_next = 14'(y_sum);
          end
          state_next = st_post;
        end
      end
      st_post: begin
        if (post_val > POST_MAX) begin
          y5 = 12'(POST_MAX) ^ UNSIGN_OFS;
        end else if (post_val < POST_MIN) begin
          y5 = 12'(POST_MIN) ^ UNSIGN_OFS;
        end else begin
          y5 = 12'(post_val) ^ UNSIGN_OFS;
        end
        if (y5 > clamp_hi) begin
          word_next = clamp_hi;
        end else if (y5 < clamp_lo) begin
          word_next = clamp_lo;
        end else begin
          word_next = y5;
        end
        pending_next = 1'b1;
        state_next   = st_idle;
      end
      default: begin
        state_next = st_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_reg <= 10'h000;
      state_reg    <= st_idle;
      y3_reg       <= 14'sd0;
      ybase_reg    <= 14'sd0;
      quo_reg      <= 21'h000000;
      rem_reg      <= 14'h0000;
      den_reg      <= 13'h0000;
      div_cnt_reg  <= 5'd0;
      neg_reg      <= 1'b0;
      extrap_reg   <= 1'b0;
      word_reg     <= 12'h000;
      pending_reg  <= 1'b0;
    end else if (clk_en) begin
      tick_cnt_reg <= tick_cnt_next;
      state_reg    <= state_next;
      y3_reg       <= y3_next;
      ybase_reg    <= ybase_next;
      quo_reg      <= quo_next;
      rem_reg      <= rem_next;
      den_reg      <= den_next;
      div_cnt_reg  <= div_cnt_next;
      neg_reg      <= neg_next;
      extrap_reg   <= extrap_next;
      word_reg     <= word_next;
      pending_reg  <= pending_next;
    end
  end

  // finished words toward the encoder
  sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (pending_reg),
    .in_ready  (fifo_ready),
    .in_data   (word_reg),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  // checks
  logic start;
  assign start = clk_en && tick && !pending_reg && (state_reg == st_idle);

  chk_tick_gap: assert property (
    @(posedge core_clk) disable iff (sys_rst || !clk_en)
    tick |=> !tick [*8])
    else $error("sample ticks too close");

  chk_bin_level: assert property (
    @(posedge core_clk) disable iff (sys_rst || !clk_en)
    start && tbl_en && bin_en && (cnt != 5'd0)
    |=> (y3_reg == Y_FIRST + 14'({$past(cnt) - 5'd1, 8'h00})) && (state_reg == st_post))
    else $error("binning level wrong");

  chk_bin_ends: assert property (
    @(posedge core_clk) disable iff (sys_rst || !clk_en)
    start && tbl_en && bin_en && ((cnt == 5'd0) || (cnt == CNT_ABOVE))
    |=> (y3_reg == BIN_BELOW) || (y3_reg == Y_LAST))
    else $error("binning end level wrong");

  chk_bypass_fwd: assert property (
    @(posedge core_clk) disable iff (sys_rst || !clk_en)
    start && !tbl_en |=> (y3_reg == 14'($past(sample_in))) && (state_reg == st_post))
    else $error("bypass did not forward sample");

  chk_div_span: assert property (
    @(posedge core_clk) disable iff (sys_rst || !clk_en)
    (state_reg != st_div) ##1 (state_reg == st_div) |-> ##21 (state_reg == st_post))
    else $error("interpolation time wrong");

  chk_interp_seg: assert property (
    @(posedge core_clk) disable iff (sys_rst || !clk_en)
    (state_reg == st_div) ##1 ((state_reg == st_post) && !extrap_reg)
    |-> (y3_reg >= ybase_reg) && (y3_reg <= ybase_reg + 14'sd256))
    else $error("interpolated value left its segment");

  chk_extrap_lim: assert property (
    @(posedge core_clk) disable iff (sys_rst || !clk_en)
    (state_reg == st_div) ##1 (state_reg == st_post)
    |-> (24'(y3_reg) >= EXTRAP_MIN) && (24'(y3_reg) <= EXTRAP_MAX))
    else $error("extrapolation beyond limit");

  chk_clamp_range: assert property (
    @(posedge core_clk) disable iff (sys_rst || !clk_en)
    (state_reg == st_post) && (clamp_lo <= clamp_hi) && !cfg_wr.en
    |=> (word_reg <= clamp_hi) && (word_reg >= clamp_lo) && pending_reg)
    else $error("result outside clamp limits");

  chk_post_done: assert property (
    @(posedge core_clk) disable iff (sys_rst || !clk_en)
    (state_reg == st_post) |=> (state_reg == st_idle) ##[0:624] $fell(pending_reg) or out_ready == 1'b0)
    else $error("post stage did not finish");

  cov_bin: cover property (@(posedge core_clk) disable iff (sys_rst) start && tbl_en && bin_en);
  cov_lin: cover property (@(posedge core_clk) disable iff (sys_rst) (state_reg == st_div) ##1 (state_reg == st_post));
  cov_bypass: cover property (@(posedge core_clk) disable iff (sys_rst) start && !tbl_en);
  cov_clamp_hi: cover property (@(posedge core_clk) disable iff (sys_rst) (state_reg == st_post) && (y5 > clamp_hi));

endmodule

// ===== sample_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two and one clock with a freeze enable.
*/
module sample_fifo
  import lin_clamp_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [AW:0]      count_reg, count_next;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      wr_ptr_next = wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (clk_en) begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        mem_reg[e] <= '0;
      end else if (clk_en && push && (wr_ptr_reg == AW'(e))) begin
        mem_reg[e] <= in_data;
      end
    end
  end

endmodule

// ===== tb_top.sv
/*
  Self-checking bench of the table, trim and clamp path.
  Assumes the design package, the design top and the far-side model.
*/
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_top
  import lin_clamp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               core_clk    = 1'b0;
  logic               sys_rst     = 1'b1;
  logic               clk_en      = 1'b1;
  cfg_write_t         cfg_wr      = '0;
  logic        [4:0]  cfg_rd_addr = 5'h00;
  logic        [23:0] cfg_rd_data;
  logic               out_valid;
  logic               out_ready;
  logic        [11:0] out_data;
  logic               hold_off    = 1'b0;
  logic               jitter_en   = 1'b0;
  logic signed [12:0] sample_in;
  logic signed [12:0] next_sample = 13'sh0000;
  int                 mismatches  = 0;
  int                 tests_run   = 0;
  int                 seed        = 53543;
  int                 cyc         = 0;
  int                 last_pop    = 0;
  int                 tbl[17];
  int                 gain        = 0;
  int                 ofs         = 0;
  int                 lo          = 0;
  int                 hi          = 4095;
  logic               en = 1'b0, bin = 1'b0, oinv = 1'b0, iinv = 1'b0;
  logic        [11:0] exp_q[$];
  logic        [11:0] e_w;

  lin_trim_clamp lin_trim_clamp_i (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .sample_in(sample_in), .cfg_wr(cfg_wr), .cfg_rd_addr(cfg_rd_addr),
    .cfg_rd_data(cfg_rd_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data));
  ends_model ends_model_i (.core_clk(core_clk), .next_sample(next_sample),
    .hold_off(hold_off), .jitter_en(jitter_en), .sample_in(sample_in), .out_ready(out_ready));

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  function automatic logic [11:0] exp_word(input logic signed [12:0] s);
    int v;
    int y;
    int n;
    v = s;
    if (en && iinv) v = (v == -4096) ? 4095 : -v;
    if (!en) y = v;
    else if (bin) begin
      n = 0;
      for (int k = 0; k < 17; k++) if (tbl[k] <= v) n = k + 1;
      y = (n == 0) ? -3072 : -2048 + 256 * (n - 1);
    end else begin
      // uniform table of slope two: exact line, then end limits
      y = 2 * v;
      y = (y < -2304) ? -2304 : (y > 2304) ? 2304 : y;
    end
    if (en && oinv) y = -y;
    y = ((y * (2048 + gain)) >>> 11) + ofs;
    y = (y < -2048) ? -2048 : (y > 2047) ? 2047 : y;
    y = y + 2048;
    y = (y > hi) ? hi : (y < lo) ? lo : y;
    return 12'(y);
  endfunction

  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge core_clk);
    #1 cfg_wr = '{en: 1'b1, addr: a, data: d};
    @(posedge core_clk);
    #1 cfg_wr.en = 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [23:0] e, input string nm);
    @(posedge core_clk);
    #1 cfg_rd_addr = a;
    repeat (2) @(posedge core_clk);
    #1 `CHK(nm, e, cfg_rd_data)
  endtask

  task automatic load();
    wr(ADDR_LIMITS, {12'(lo), 12'(hi)});
    for (int k = 0; k < 8; k++) wr(ADDR_TABLE0 + 5'(k), {12'(tbl[2*k+1]), 12'(tbl[2*k])});
    wr(ADDR_TAIL, {8'h00, iinv, oinv, bin, en, 12'(tbl[16])});
    wr(ADDR_POST, {12'(ofs), 12'(gain)});
  endtask

  task automatic drain();
    for (int i = 0; i < 1500 && exp_q.size() > 0; i++) @(posedge core_clk);
  endtask

  task automatic step(input logic signed [12:0] s);
    drain();
    load();
    @(posedge core_clk);
    #1 next_sample = s;
    exp_q.push_back(exp_word(s));
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // result watcher: every popped word against the oldest note
  always @(posedge core_clk) if (out_valid === 1'b1 && out_ready === 1'b1) begin
    last_pop = cyc;
    e_w = (exp_q.size() > 0) ? exp_q.pop_front() : 12'hxxx;
    `CHK("out_data", e_w, out_data)
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    print_verdict();
  end

  initial begin
    int t1;
    for (int k = 0; k < 17; k++) tbl[k] = -1024 + 128 * k;
    next_sample = 13'($random(seed));
    exp_q.push_back(exp_word(next_sample));
    repeat (5) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    rd(ADDR_LIMITS, LIMITS_RST, "limits");
    rd(ADDR_TABLE0, TABLE_RST, "table0");
    rd(ADDR_POST, POST_RST, "post");
    wr(ADDR_TAIL, 24'hffffff);
    rd(ADDR_TAIL, 24'h00ffff, "tail");
    wr(5'h05, 24'h123456);
    rd(5'h05, 24'h000000, "unmapped");
    wr(ADDR_TAIL, 24'h000000);
    jitter_en = 1'b1;
    repeat (5) begin
      gain = $signed(12'($random(seed)));
      ofs = $signed(12'($random(seed)));
      step(13'($random(seed)));
    end
    jitter_en = 1'b0;
    gain = 0;
    ofs = 0;
    step(13'sh0100);
    drain();
    t1 = last_pop;
    // frozen enable stretches the tick spacing by the frozen edges
    @(posedge core_clk);
    #1 clk_en = 1'b0;
    repeat (10) @(posedge core_clk);
    #1 clk_en = 1'b1;
    step(-13'sh0100);
    drain();
    `CHK("tick spacing", TICK_CYCLES + 10, last_pop - t1)
    lo = 409;
    hi = 3686;
    step(-13'sd2048);
    step(13'sd2047);
    step(-13'sd1639);
    step(-13'sd1640);
    lo = 0;
    hi = 4095;
    en = 1'b1;
    bin = 1'b1;
    gain = -1024;
    tbl[2] = -700;
    tbl[3] = -700;
    tbl[4] = -700;
    step(-13'sd1025);
    step(-13'sd1024);
    step(-13'sd701);
    step(-13'sd700);
    step(13'sd1023);
    step(13'sd1024);
    step(13'sd2047);
    for (int f = 0; f < 4; f++) begin
      {iinv, oinv} = 2'(f);
      step(-13'sd701);
    end
    step(-13'sd4096);
    iinv = 1'b0;
    oinv = 1'b0;
    bin = 1'b0;
    tbl[2] = -768;
    tbl[3] = -640;
    tbl[4] = -512;
    step(-13'sd1500);
    step(13'sd1500);
    repeat (4) step(13'($random(seed)));
    en = 1'b0;
    bin = 1'b1;
    {iinv, oinv} = 2'b11;
    gain = 0;
    step(13'sd300);
    bin = 1'b0;
    {iinv, oinv} = 2'b00;
    // encoder stalls: four words buffered, one pending, sixth tick dropped
    drain();
    load();
    @(posedge core_clk);
    #1 hold_off = 1'b1;
    next_sample = 13'sd77;
    repeat (5) exp_q.push_back(exp_word(13'sd77));
    repeat (3950) @(posedge core_clk);
    #1 `CHK("held valid", 1'b1, out_valid)
    `CHK("held word", exp_word(13'sd77), out_data)
    next_sample = -13'sd77;
    exp_q.push_back(exp_word(-13'sd77));
    hold_off = 1'b0;
    drain();
    `CHK("words left", 0, exp_q.size())
    print_verdict();
  end
endmodule
